// File: shared/qsc_map.svh
`ifndef QSC_MAP_SVH
`define QSC_MAP_SVH
// ============================================================
// Register word addresses
`define QSC_A_CR0    8'h00
`define QSC_A_CR1    8'h01
`define QSC_A_CR2    8'h02
`define QSC_A_CR3    8'h03
`define QSC_A_STAT   8'h04
`define QSC_A_IDLE   8'h05
// ============================================================
// Queue RAM pages (upper address nibble)
`define QSC_P_TX     4'h1
`define QSC_P_RX     4'h2
`define QSC_P_CMD    4'h3
// ============================================================
// Command byte fields
`define QSC_CMD_KEEP_SELECT_ASSERTED 7
`define QSC_CMD_DT   5
// ============================================================
// Delay counts in system clock cycles, and the shift applied to the programmed count
`define QSC_STD_DLY  14'h0011
`define QSC_ZERO_DLY 14'h2000
`define QSC_DLY_SH   5
`endif

// File: shared/qsc_pkg.sv
package qsc_pkg;
    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_LOAD  = 6'b000010,
        S_XFER  = 6'b000100,
        S_STORE = 6'b001000,
        S_PAUSE = 6'b010000,
        S_DELAY = 6'b100000
    } qsc_seq_t;
    typedef enum logic [2:0] {
        T_IDLE  = 3'b001,
        T_LEAD  = 3'b010,
        T_SHIFT = 3'b100
    } qsc_shf_t;
endpackage

// File: shared/qsc_shift_if.sv
interface qsc_shift_if;
    logic        start;
    logic [15:0] txd;
    logic [3:0]  len;
    logic [7:0]  div;
    logic [6:0]  lead;
    logic        cpol;
    logic        cpha;
    logic        loop;
    logic        miso;
    logic        done;
    logic [15:0] rxd;
    logic        sck;
    logic        mosi;
    modport ctl (output start, txd, len, div, lead, cpol, cpha, loop,
                 miso, input done, rxd, sck, mosi);
    modport shf (input start, txd, len, div, lead, cpol, cpha, loop,
                 miso, output done, rxd, sck, mosi);
endinterface

// File: hw/qsc_shifter.sv
module qsc_shifter (
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    qsc_shift_if.shf   s
);
    // ========================================================
    // Derived settings
    qsc_pkg::qsc_shf_t st_q;
    logic [7:0]  cnt_q;
    logic [4:0]  edge_q;
    logic [15:0] sh_q;
    logic [15:0] rx_q;
    logic        ph_q;
    logic        out_q;
    logic        done_q;
    wire  [4:0]  nbits = (s.len == 4'h0) ? 5'h10 : {1'b0, s.len};
    wire  [15:0] algn  = s.txd << (5'h10 - nbits);
    wire  [7:0]  half  = (s.div == 8'h00) ? 8'h01 : s.div;
    wire  [7:0]  leadn = (s.lead == 7'h00) ? 8'h01 : {1'b0, s.lead};
    wire         lead_e = ~ph_q;
    wire         samp  = lead_e ^ s.cpha;
    // Last of 2n edges; n-1 fits in 4 bits even for a 16-bit frame
    wire  [3:0]  nlast = 4'(nbits - 5'h01);
    wire         last  = (edge_q == {nlast, 1'b1});
    wire         rxin  = s.loop ? out_q : s.miso;
    assign s.sck  = s.cpol ^ ph_q;
    assign s.mosi = out_q;
    assign s.rxd  = rx_q;
    assign s.done = done_q;
    // ========================================================
    // Lead delay then one clock edge per half period
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= qsc_pkg::T_IDLE;
            cnt_q  <= 8'h00;
            edge_q <= 5'h00;
            sh_q   <= 16'h0000;
            rx_q   <= 16'h0000;
            ph_q   <= 1'b0;
            out_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                qsc_pkg::T_IDLE: begin
                    if (s.start) begin
                        st_q   <= qsc_pkg::T_LEAD;
                        cnt_q  <= leadn - 8'h01;
                        edge_q <= 5'h00;
                        ph_q   <= 1'b0;
                        out_q  <= s.cpha ? out_q : algn[15];
                        sh_q   <= s.cpha ? algn : (algn << 1);
                    end
                end
                qsc_pkg::T_LEAD: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        st_q  <= qsc_pkg::T_SHIFT;
                        cnt_q <= half - 8'h01;
                    end
                end
                qsc_pkg::T_SHIFT: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00) begin
                        cnt_q  <= half - 8'h01;
                        ph_q   <= ~ph_q;
                        edge_q <= edge_q + 5'h01;
                        if (samp) begin
                            rx_q <= {rx_q[14:0], rxin};
                        end else begin
                            out_q <= sh_q[15];
                            sh_q  <= sh_q << 1;
                        end
                        if (last) begin
                            st_q   <= qsc_pkg::T_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
    // ========================================================
    // Checks
    a_edge_count: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        done_q |-> (edge_q == {nbits[3:0], 1'b0}) && !ph_q)
        else $error("edge count wrong at end of transfer");
endmodule // qsc_shifter

// File: hw/qsc_top.sv
`include "qsc_map.svh"
// Function
// - Programmed delay lasts 32 times the count, for counts 1 to 255.
// - Programmed count of zero gives 8192 cycles.
// - Command delay bit picks standard or programmed delay.
// - Standard delay after a transfer is 17 cycles.
// - Enabling in master mode starts the queue at the new queue pointer; in slave mode it sets mode fault.
// - Transmit word at pointer goes out; received word stored there.
// - After last bit, pointer copied to completed pointer, then incremented.
// - Written new pointer takes effect after the running transfer.
// - Keep-select commands hold selects during and between transfers.
// - Changed select pattern waits until next transfer begins.
// - Without keep-select, idle data drives pins between transfers.
// - Queue end sets done flag; enable raises interrupt.
// - Queue end clears enable and stops unless wrap is on.
// - End pointer, wrap enable and wrap target steer queue end.
// - Rate, phase, polarity, length, master and open-drain apply.
// - Pause at queue end, pause/fault interrupt and loopback apply.
// - Lead delay count is inserted before each transfer.
// - After reset nothing runs until software enables it.
module qsc_top #(
    parameter int QD = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             irq,
    output logic             sck_o,
    output logic             sck_oe,
    output logic             mosi_o,
    output logic             mosi_oe,
    output logic      [3:0]  pcs_o,
    output logic      [3:0]  pcs_oe,
    input  wire logic        miso_i
);
    // ========================================================
    // Parameter check
    if (QD < 2 || QD > 16 || (QD & (QD - 1)) != 0) begin : g_chk
        $error("QD must be a power of two from 2 to 16");
    end
    localparam logic [3:0] QM = 4'(QD - 1);

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic page(input logic [7:0] a,
                                  input logic [3:0] pg);
        page = (a[7:4] == pg) && ((a[3:0] & ~QM) == 4'h0);
    endfunction

    // ========================================================
    // Registers and memories
    logic [7:0]  br_q;
    logic        cpha_q;
    logic        cpol_q;
    logic [3:0]  bits_q;
    logic        controller_select_q;
    logic        open_drain_select_q;
    logic [7:0]  dtl_q;
    logic [6:0]  lead_q;
    logic        spe_q;
    logic [3:0]  nqp_q;
    logic [3:0]  eqp_q;
    logic [3:0]  wrap_target_q;
    logic        wrap_enable_q;
    logic        queue_done_irq_enable_q;
    logic        halt_q;
    logic        pause_fault_irq_enable_q;
    logic        loop_q;
    logic        queue_done_flag_q;
    logic        haltf_q;
    logic        modf_q;
    logic [3:0]  cpt_q;
    logic [5:0]  idle_q;
    logic        npend_q;
    logic [3:0]  ptr_q;
    logic [13:0] dly_q;
    logic [7:0]  cmd_l_q;
    logic        miso_s1_q;
    logic        miso_s2_q;
    logic [15:0] tx_mem  [QD];
    logic [15:0] rx_mem  [QD];
    logic [7:0]  cmd_mem [QD];
    qsc_pkg::qsc_seq_t st_q;
    qsc_pkg::qsc_seq_t st_d;

    qsc_shift_if u_sif ();

    // ========================================================
    // Bus decode
    wire we_cr0  = wr && hit(addr, `QSC_A_CR0);
    wire we_cr1  = wr && hit(addr, `QSC_A_CR1);
    wire we_cr2  = wr && hit(addr, `QSC_A_CR2);
    wire we_cr3  = wr && hit(addr, `QSC_A_CR3);
    wire we_stat = wr && hit(addr, `QSC_A_STAT);
    wire we_idle = wr && hit(addr, `QSC_A_IDLE);
    wire we_tx   = wr && page(addr, `QSC_P_TX);
    wire we_cmd  = wr && page(addr, `QSC_P_CMD);
    wire [3:0] ai = addr[3:0] & QM;

    // ========================================================
    // Sequencer decode
    wire [3:0]  pi     = ptr_q & QM;
    wire [7:0]  cmd_w  = cmd_mem[pi];
    wire        keep_select_asserted   = cmd_l_q[`QSC_CMD_KEEP_SELECT_ASSERTED];
    wire        dt     = cmd_l_q[`QSC_CMD_DT];
    wire        at_end = (ptr_q == eqp_q);
    wire [3:0]  ptr_in = (ptr_q + 4'h1) & QM;
    wire [3:0]  ptr_n  = npend_q ? nqp_q :
                         (at_end && wrap_enable_q) ? wrap_target_q :
                         ptr_in;
    wire [13:0] dly_p  = (dtl_q == 8'h00) ? `QSC_ZERO_DLY
                       : {1'b0, dtl_q, 5'h00};
    wire [13:0] dly_n  = dt ? dly_p : `QSC_STD_DLY;
    wire        store  = (st_q == qsc_pkg::S_STORE);
    wire        start  = (st_q == qsc_pkg::S_IDLE) && spe_q && controller_select_q;
    wire        fault  = (st_q == qsc_pkg::S_IDLE) && spe_q && !controller_select_q;
    wire        dly_ok = (st_q == qsc_pkg::S_DELAY) && (dly_q == 14'h1);
    wire        stop   = store && at_end && !wrap_enable_q;
    wire        done_e = store && at_end;

    // ========================================================
    // Shifter hookup
    assign u_sif.start = (st_q == qsc_pkg::S_LOAD);
    assign u_sif.txd   = tx_mem[pi];
    assign u_sif.len   = bits_q;
    assign u_sif.div   = br_q;
    assign u_sif.lead  = lead_q;
    assign u_sif.cpol  = cpol_q;
    assign u_sif.cpha  = cpha_q;
    assign u_sif.loop  = loop_q;
    assign u_sif.miso  = miso_s2_q;

    qsc_shifter u_shf (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .s       (u_sif)
    );

    // ========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            qsc_pkg::S_IDLE:  if (start) st_d = qsc_pkg::S_LOAD;
            qsc_pkg::S_LOAD:  st_d = qsc_pkg::S_XFER;
            qsc_pkg::S_XFER:  if (u_sif.done) st_d = qsc_pkg::S_STORE;
            qsc_pkg::S_STORE: st_d = (at_end && halt_q) ?
                                     qsc_pkg::S_PAUSE : qsc_pkg::S_DELAY;
            qsc_pkg::S_PAUSE: if (!halt_q) st_d = qsc_pkg::S_DELAY;
            qsc_pkg::S_DELAY: if (dly_ok) st_d = spe_q ?
                                     qsc_pkg::S_LOAD : qsc_pkg::S_IDLE;
        endcase
    end

    // ========================================================
    // Pin values; transfer pins come from the shifter only in XFER
    wire       xfer   = (st_q == qsc_pkg::S_XFER);
    wire [3:0] pcs_hd = keep_select_asserted ? cmd_l_q[3:0] : idle_q[5:2];
    wire [3:0] pcs_d  = xfer ? cmd_l_q[3:0] : pcs_hd;
    wire       sck_d  = xfer ? u_sif.sck  : idle_q[0];
    wire       mosi_d = xfer ? u_sif.mosi : idle_q[1];
    wire       irq_d  = (queue_done_flag_q && queue_done_irq_enable_q) ||
                        ((haltf_q || modf_q) && pause_fault_irq_enable_q);

    // ========================================================
    // Read mux
    wire [15:0] rd_d =
        hit(addr, `QSC_A_CR0)  ? {open_drain_select_q, controller_select_q, bits_q, cpol_q,
                                  cpha_q, br_q} :
        hit(addr, `QSC_A_CR1)  ? {spe_q, lead_q, dtl_q} :
        hit(addr, `QSC_A_CR2)  ? {2'h0, queue_done_irq_enable_q, wrap_enable_q, wrap_target_q,
                                  eqp_q, nqp_q} :
        hit(addr, `QSC_A_CR3)  ? {13'h0000, loop_q, pause_fault_irq_enable_q, halt_q} :
        hit(addr, `QSC_A_STAT) ? {4'h0, cpt_q, 5'h00, modf_q,
                                  haltf_q, queue_done_flag_q} :
        hit(addr, `QSC_A_IDLE) ? {10'h000, idle_q} :
        page(addr, `QSC_P_TX)  ? tx_mem[ai] :
        page(addr, `QSC_P_RX)  ? rx_mem[ai] :
        page(addr, `QSC_P_CMD) ? {8'h00, cmd_mem[ai]} : 16'h0000;

    // ========================================================
    // Configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {open_drain_select_q, controller_select_q, bits_q, cpol_q, cpha_q, br_q} <= 16'h0000;
            {lead_q, dtl_q}          <= 15'h0000;
            {queue_done_irq_enable_q, wrap_enable_q}       <= 2'h0;
            {wrap_target_q, eqp_q, nqp_q}   <= 12'h000;
            {loop_q, pause_fault_irq_enable_q, halt_q} <= 3'h0;
            idle_q                   <= 6'h00;
        end else begin
            if (we_cr0) begin
                {open_drain_select_q, controller_select_q, bits_q, cpol_q, cpha_q, br_q} <= wdata;
            end
            if (we_cr1) begin
                {lead_q, dtl_q} <= wdata[14:0];
            end
            if (we_cr2) begin
                {queue_done_irq_enable_q, wrap_enable_q, wrap_target_q, eqp_q, nqp_q} <= wdata[13:0];
            end
            if (we_cr3) begin
                {loop_q, pause_fault_irq_enable_q, halt_q} <= wdata[2:0];
            end
            if (we_idle) begin
                idle_q <= wdata[5:0];
            end
        end
    end

    // ========================================================
    // Enable and status; hardware sets win over software clears
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            spe_q   <= 1'b0;
            queue_done_flag_q  <= 1'b0;
            haltf_q <= 1'b0;
            modf_q  <= 1'b0;
            npend_q <= 1'b0;
        end else begin
            if (we_cr1) begin
                spe_q <= wdata[15];
            end else if (stop || fault) begin
                spe_q <= 1'b0;
            end
            queue_done_flag_q  <= done_e || (queue_done_flag_q && !(we_stat && !wdata[0]));
            haltf_q <= (store && at_end && halt_q) ||
                       (haltf_q && !(we_stat && !wdata[1]));
            modf_q  <= fault || (modf_q && !(we_stat && !wdata[2]));
            // A write in the consuming cycle stays pending
            npend_q <= we_cr2 || (npend_q && !store && !start);
        end
    end

    // ========================================================
    // Sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= qsc_pkg::S_IDLE;
            ptr_q   <= 4'h0;
            cpt_q   <= 4'h0;
            dly_q   <= 14'h0000;
            cmd_l_q <= 8'h00;
        end else begin
            st_q <= st_d;
            if (start) begin
                ptr_q <= nqp_q & QM;
            end
            if (st_q == qsc_pkg::S_LOAD) begin
                cmd_l_q <= cmd_w;
            end
            if (store) begin
                cpt_q <= ptr_q;
                ptr_q <= ptr_n & QM;
                dly_q <= dly_n;
            end
            if (st_q == qsc_pkg::S_DELAY) begin
                dly_q <= dly_q - 14'h0001;
            end
        end
    end

    // ========================================================
    // Memories have no reset; software fills them before use
    always_ff @(posedge sys_clk) begin
        if (we_tx) begin
            tx_mem[ai] <= wdata;
        end
        if (we_cmd) begin
            cmd_mem[ai] <= wdata[7:0];
        end
        if (xfer && u_sif.done) begin
            rx_mem[pi] <= u_sif.rxd;
        end
    end

    // ========================================================
    // Output flops and input synchroniser
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata     <= 16'h0000;
            irq       <= 1'b0;
            sck_o     <= 1'b0;
            mosi_o    <= 1'b0;
            pcs_o     <= 4'h0;
            sck_oe    <= 1'b0;
            mosi_oe   <= 1'b0;
            pcs_oe    <= 4'h0;
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            rdata     <= rd ? rd_d : 16'h0000;
            irq       <= irq_d;
            sck_o     <= sck_d;
            mosi_o    <= mosi_d;
            pcs_o     <= pcs_d;
            // Open-drain mode drives only low levels
            sck_oe    <= open_drain_select_q ? !sck_d : 1'b1;
            mosi_oe   <= open_drain_select_q ? !mosi_d : 1'b1;
            pcs_oe    <= open_drain_select_q ? ~pcs_d : 4'hF;
            miso_s1_q <= miso_i;
            miso_s2_q <= miso_s1_q;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic [13:0] seen_q;
    logic [7:0]  dtl_l_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q  <= 14'h0000;
            dtl_l_q <= 8'h00;
        end else begin
            seen_q <= (st_q == qsc_pkg::S_DELAY) ?
                      seen_q + 14'h0001 : 14'h0000;
            if (store) begin
                dtl_l_q <= dtl_q;
            end
        end
    end

    a_std_delay: assert property (
        dly_ok && !dt |-> seen_q == `QSC_STD_DLY - 14'h0001)
        else $error("standard delay length wrong");
    a_prog_delay: assert property (
        dly_ok && dt && dtl_l_q != 8'h00 |->
        seen_q == {1'b0, dtl_l_q, 5'h00} - 14'h0001)
        else $error("programmed delay length wrong");
    a_zero_delay: assert property (
        dly_ok && dt && dtl_l_q == 8'h00 |->
        seen_q == `QSC_ZERO_DLY - 14'h0001)
        else $error("zero-count delay length wrong");
    a_queue_start: assert property (
        start && !we_cr2 |=> st_q == qsc_pkg::S_LOAD ##1
        u_sif.start == 1'b0 && st_q == qsc_pkg::S_XFER)
        else $error("queue did not start");
    a_cpt_update: assert property (
        store |=> cpt_q == $past(ptr_q))
        else $error("completed pointer not updated");
    a_done_flag: assert property (
        done_e |=> queue_done_flag_q ##1 irq == ($past(queue_done_flag_q) && $past(queue_done_irq_enable_q)
        || (($past(haltf_q) || $past(modf_q)) && $past(pause_fault_irq_enable_q))))
        else $error("done flag or interrupt wrong");
    a_stop_end: assert property (
        stop && !we_cr1 |=> !spe_q)
        else $error("enable not cleared at queue end");
    a_wrap: assert property (
        done_e && wrap_enable_q && !npend_q |=> ptr_q == $past(wrap_target_q & QM))
        else $error("wrap target not taken");
    a_hold_pcs: assert property (
        st_q == qsc_pkg::S_DELAY && keep_select_asserted |=> pcs_o == $past(cmd_l_q[3:0]))
        else $error("selects not held between transfers");
    a_idle_pins: assert property (
        st_q == qsc_pkg::S_DELAY && !keep_select_asserted |=>
        {pcs_o, mosi_o, sck_o} == $past(idle_q))
        else $error("idle data not driven");
endmodule // qsc_top

// File: dv/qsc_periph.sv
module qsc_periph (
    input  wire logic        sck,
    input  wire logic        mosi,
    input  wire logic        sel_n,
    input  wire logic        clr,
    input  wire logic [15:0] pat,
    output logic             miso,
    output logic      [15:0] got,
    output logic      [4:0]  edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh;
    logic [15:0] frm;
    initial begin
        miso = 1'b0;
        frm = 16'h0000;
        got = 16'h0000;
        edges = 5'h00;
    end
    // Released line flips so a stale bit never looks valid
    always @(posedge sel_n) miso = ~miso;
    always @(posedge clr) frm = 16'h0000;
    // Frame n answers pat xor n, so misplaced stores show
    always @(negedge sel_n) begin
        sh = pat ^ frm;
        frm = frm + 16'h0001;
        edges = 5'h00;
        miso = sh[15];
    end
    always @(posedge sck) if (!sel_n) begin
        got = {got[14:0], mosi};
        edges = edges + 5'h01;
    end
    always @(negedge sck) if (!sel_n) begin
        sh = sh << 1;
        miso = sh[15];
    end
endmodule // qsc_periph

// File: dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        irq;
    logic        sck_o;
    logic        mosi_o;
    logic [3:0]  pcs_o;
    logic        miso_i;
    logic        clr;
    logic [15:0] pat;
    logic [15:0] got;
    logic [4:0]  edges;
    logic [15:0] tx [3];
    logic [15:0] rv;
    logic [31:0] seed;
    logic [7:0]  after_transfer_delay_count;
    int          err_count;
    int          compares;
    int          gaps [$];
    int          gcnt;
    int          base;
    qsc_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .sck_o(sck_o), .sck_oe(), .mosi_o(mosi_o), .mosi_oe(),
        .pcs_o(pcs_o), .pcs_oe(), .miso_i(miso_i));
    qsc_periph PER (.sck(sck_o), .mosi(mosi_o), .sel_n(pcs_o[0]),
        .clr(clr), .pat(pat), .miso(miso_i), .got(got), .edges(edges));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ====
    // Idle gap between frames, in cycles with all selects high
    always @(posedge sys_clk) begin
        if (pcs_o === 4'hF)
            gcnt <= gcnt + 1;
        else if (gcnt != 0) begin
            gaps.push_back(gcnt);
            gcnt <= 0;
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic end_sim;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Read data is taken at the edge after the strobe cycle only
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge sys_clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        // Sample mid-cycle, while the read word stands
        @(negedge sys_clk);
        rv = rdata;
    endtask
    task automatic wait_irq(input logic lvl);
        int i;
        for (i = 0; i < 20000 && irq !== lvl; i++)
            @(posedge sys_clk);
        chk("irq", {15'h0000, lvl}, {15'h0000, irq});
        if (i == 20000)
            end_sim();
    endtask
    task automatic run(input logic [3:0] last);
        clr <= 1'b1;
        gaps.delete();
        bus(1'b1, 8'h02, {3'b001, 1'b0, 4'h0, last, 4'h0});
        bus(1'b1, 8'h01, {1'b1, 7'h03, after_transfer_delay_count});
        clr <= 1'b0;
        wait_irq(1'b1);
    endtask
    // ====
    // Main sequence
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        clr = 1'b0;
        gcnt = 0;
        seed = 32'h00001D10;
        pat = xs();
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h04, 16'h0000);
        chk("status", 16'h0000, rv);
        chk("pcs", 16'h0000, {12'h000, pcs_o});
        bus(1'b0, 8'h0F, 16'h0000);
        chk("unmapped", 16'h0000, rv);
        bus(1'b1, 8'h05, 16'h003C);
        bus(1'b1, 8'h00, 16'h4004);
        chk("idle", 16'h000F, {12'h000, pcs_o});
        for (int i = 0; i < 3; i++) begin
            tx[i] = xs();
            bus(1'b1, 8'h10 + 8'(i), tx[i]);
            bus(1'b1, 8'h30 + 8'(i), {10'h000, i == 1, 5'h0E});
        end
        after_transfer_delay_count = 8'h01 + {5'h00, xs() & 32'h7};
        run(4'h2);
        chk("dly", 16'(32 * after_transfer_delay_count - 17), 16'(gaps[2] - gaps[1]));
        bus(1'b0, 8'h04, 16'h0000);
        chk("cptr", 16'h0201, rv);
        bus(1'b0, 8'h01, 16'h0000);
        chk("spe", {1'b0, 7'h03, after_transfer_delay_count}, rv);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 8'h20 + 8'(i), 16'h0000);
            chk("rx", pat ^ 16'(i), rv);
        end
        chk("mosi", tx[2], got);
        chk("edges", 16'h0010, {11'h000, edges});
        bus(1'b1, 8'h04, 16'h0000);
        wait_irq(1'b0);
        base = gaps[1] - 17;
        after_transfer_delay_count = 8'h00;
        bus(1'b1, 8'h30, 16'h002E);
        run(4'h1);
        chk("zero", 16'(base + 8192), 16'(gaps[1]));
        end_sim();
    end
endmodule // testbench
